// ==== src/ncm_pkg.sv ====
package ncm_pkg;
  // apb map
  localparam int          APB_AW      = 12;
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STAT    = 12'h004;
  localparam logic [11:0] OFS_MASK    = 12'h008;
  localparam logic [11:0] OFS_STATE   = 12'h00C;
  localparam logic [11:0] OFS_CMD     = 12'h040;
  localparam logic [11:0] OFS_RSP     = 12'h080;
  localparam int          CMD_WORDS   = 12;
  localparam int          RSP_WORDS   = 13;
  localparam int          DATA_WORDS  = 4;
  // bit positions
  localparam int          CTRL_GO     = 0;
  localparam int          CTRL_INIT   = 1;
  localparam int          EV_DONE     = 0;
  localparam int          EV_FAULT    = 1;
  localparam int          EV_W        = 2;
  localparam int          ST_DHCP     = 0;
  localparam int          ST_BUSY     = 1;
  localparam int          ST_SEC      = 2;
  localparam int          ST_SMTP     = 3;
  // message word positions
  localparam int          W_ID        = 0;
  localparam int          W_INFO      = 1;
  localparam int          W_CODE      = 2;
  localparam int          W_SIZE      = 3;
  localparam int          W_FCNT      = 4;
  localparam int          W_FNUM      = 5;
  localparam int          W_OFSH      = 6;
  localparam int          W_OFSL      = 7;
  localparam int          W_FAULT     = 8;
  localparam int          CMD_DATA    = 8;
  localparam int          RSP_DATA    = 9;
  // message field values
  localparam logic [15:0] CODE_DHCP_ON = 16'h001A;
  localparam logic [15:0] CODE_DNS_WR  = 16'h0031;
  localparam logic [15:0] CODE_DNS_RD  = 16'h0033;
  localparam logic [15:0] CODE_SMTP_WR = 16'h000E;
  localparam logic [15:0] SIZE_NONE    = 16'h0000;
  localparam logic [15:0] SIZE_DNS     = 16'h0008;
  localparam logic [15:0] SIZE_SMTP    = 16'h0004;
  localparam logic [15:0] INFO_CMD     = 16'h4002;
  localparam logic [15:0] INFO_RSP     = 16'h0002;
  localparam logic [15:0] FRAME_ONE    = 16'h0001;
  localparam logic [15:0] OFFSET_ZERO  = 16'h0000;
  localparam logic [15:0] FAULT_NONE   = 16'h0000;
  localparam logic [15:0] FAULT_INIT   = 16'h0001;
  localparam logic [15:0] FAULT_FRAME  = 16'h0002;
  localparam logic [15:0] FAULT_CODE   = 16'h0003;

  typedef enum logic [2:0] {
    CK_NONE, CK_DHCP_ON, CK_DNS_WR, CK_DNS_RD, CK_SMTP_WR
  } ncm_cmd_type;

  typedef enum {S_IDLE, S_EXEC} ncm_state_type;
endpackage

// ==== src/ncm_core_if.sv ====
`timescale 1ns/100ps
interface ncm_core_if;
  import ncm_pkg::*;
  logic [15:0]   code;
  logic [15:0]   size;
  logic [15:0]   info;
  logic [15:0]   fcnt;
  logic [15:0]   fnum;
  logic [15:0]   ofsh;
  logic [15:0]   ofsl;
  ncm_cmd_type   kind;
  logic          frame_ok;
  logic          size_ok;
  logic          restricted;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] mask_val;
  logic          mask_we;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic          irq;

  modport dec_side (input code, size, info, fcnt, fnum, ofsh, ofsl,
                    output kind, frame_ok, size_ok, restricted);
  modport irq_side (input ev, clr, mask_val, mask_we,
                    output status, mask, irq);
  modport core (output code, size, info, fcnt, fnum, ofsh, ofsl,
                ev, clr, mask_val, mask_we,
                input kind, frame_ok, size_ok, restricted,
                status, mask, irq);
endinterface

// ==== src/ncm_dec.sv ====
`timescale 1ns/100ps
module ncm_dec
  import ncm_pkg::*;
(
  ncm_core_if.dec_side c
);

  function automatic logic [15:0] exp_size(input ncm_cmd_type k);
    logic [15:0] s;
    s = SIZE_NONE;
    if (k == CK_DNS_WR) begin
      s = SIZE_DNS;
    end else if (k == CK_SMTP_WR) begin
      s = SIZE_SMTP;
    end
    return s;
  endfunction

  assign c.kind = (c.code == CODE_DHCP_ON) ? CK_DHCP_ON :
                  (c.code == CODE_DNS_WR)  ? CK_DNS_WR  :
                  (c.code == CODE_DNS_RD)  ? CK_DNS_RD  :
                  (c.code == CODE_SMTP_WR) ? CK_SMTP_WR : CK_NONE;

  // single frame only, no segment offset
  assign c.frame_ok = (c.info == INFO_CMD) && (c.fcnt == FRAME_ONE) &&
                      (c.fnum == FRAME_ONE) && (c.ofsh == OFFSET_ZERO) &&
                      (c.ofsl == OFFSET_ZERO);
  assign c.size_ok  = (c.size == exp_size(c.kind));
  // setting commands belong to the init phase only
  assign c.restricted = (c.kind != CK_NONE) && (c.kind != CK_DNS_RD);
endmodule

// ==== src/ncm_irq.sv ====
`timescale 1ns/100ps
module ncm_irq
  import ncm_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  ncm_core_if.irq_side c
);

  // set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c.status <= '0;
      c.mask   <= '0;
    end else begin
      c.status <= (c.status & ~c.clr) | c.ev;
      if (c.mask_we) begin
        c.mask <= c.mask_val;
      end
    end
  end

  assign c.irq = |(c.status & c.mask);
endmodule

// ==== src/ncm_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - code 001Ah, size zero: DHCP on
// - DHCP on shows on web and ipconfig
// - DHCP off after reset unless the stored file enables it
// - DHCP and DNS write report acceptance
// - code 0031h stores primary, secondary DNS
// - zero secondary means primary only
// - code 0033h answers eight bytes of DNS
// - unused DNS slot reads as zero
// - code 000Eh sets SMTP server address
// - commanded SMTP beats stored file
// - SMTP write response echoes both words
module ncm_top
  import ncm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              cfg_file_dhcp,
  input  wire logic [31:0]       cfg_file_smtp,
  output logic                   dhcp_on,
  output logic                   web_dhcp_checkbox,
  output logic                   ipcfg_dhcp_visible,
  output logic      [31:0]       dns_primary,
  output logic      [31:0]       dns_secondary,
  output logic                   dns_secondary_used,
  output logic      [31:0]       smtp_server
);

  ncm_core_if c ();

  logic [15:0]   cmd_mem [CMD_WORDS];
  logic [15:0]   rsp_mem [RSP_WORDS];
  logic [15:0]   next_rsp [RSP_WORDS];
  logic [15:0]   dns_word [DATA_WORDS];
  logic [63:0]   cmd_data;
  ncm_state_type state;
  ncm_state_type next_state;
  logic          init_phase;
  logic          dhcp_cmd;
  logic [31:0]   dns_pri;
  logic [31:0]   dns_sec;
  logic [31:0]   smtp_cmd;
  logic          smtp_override;
  logic [15:0]   fault_w;
  logic [31:0]   rd_val;

  ////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic hit(input logic [APB_AW-1:0] a,
                               input logic [APB_AW-1:0] b,
                               input int n);
    return (a >= b) && (a < b + APB_AW'(4 * n)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] idx(input logic [APB_AW-1:0] a,
                                     input logic [APB_AW-1:0] b);
    return 4'((a - b) >> 2);
  endfunction

  wire access   = psel && penable;
  wire setup    = psel && !penable;
  wire sel_ctrl = (paddr == OFS_CTRL);
  wire sel_stat = (paddr == OFS_STAT);
  wire sel_mask = (paddr == OFS_MASK);
  wire sel_st   = (paddr == OFS_STATE);
  wire sel_cmd  = hit(paddr, OFS_CMD, CMD_WORDS);
  wire sel_rsp  = hit(paddr, OFS_RSP, RSP_WORDS);
  wire mapped   = sel_ctrl | sel_stat | sel_mask | sel_st | sel_cmd |
                  sel_rsp;
  // response buffer is read only, a write there is an error
  wire bad      = !mapped || (pwrite && (sel_rsp || sel_st));
  wire wr       = access && pwrite && !bad;
  wire [3:0] cmd_i = idx(paddr, OFS_CMD);
  wire [3:0] rsp_i = idx(paddr, OFS_RSP);
  wire busy     = (state == S_EXEC);
  wire start    = wr && sel_ctrl && pwdata[CTRL_GO] && !busy;
  wire exec     = busy;

  assign pready  = 1'b1;
  assign pslverr = access && bad;

  always_comb begin
    rd_val = '0;
    if (sel_ctrl) begin
      rd_val[CTRL_INIT] = init_phase;
    end else if (sel_stat) begin
      rd_val = 32'(c.status);
    end else if (sel_mask) begin
      rd_val = 32'(c.mask);
    end else if (sel_st) begin
      rd_val[ST_DHCP] = dhcp_on;
      rd_val[ST_BUSY] = busy;
      rd_val[ST_SEC]  = dns_secondary_used;
      rd_val[ST_SMTP] = smtp_override;
    end else if (sel_cmd) begin
      rd_val = 32'(cmd_mem[cmd_i]);
    end else if (sel_rsp) begin
      rd_val = 32'(rsp_mem[rsp_i]);
    end
  end

  // read data latched in setup so it is stable for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register and command buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_phase <= 1'b1;
    end else if (wr && sel_ctrl) begin
      init_phase <= pwdata[CTRL_INIT];
    end
  end

  // buffer frozen while a command executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CMD_WORDS; i++) begin
        cmd_mem[i] <= '0;
      end
    end else if (wr && sel_cmd && !busy) begin
      cmd_mem[cmd_i] <= pwdata[15:0];
    end
  end

  assign cmd_data = {cmd_mem[CMD_DATA], cmd_mem[CMD_DATA + 1],
                     cmd_mem[CMD_DATA + 2], cmd_mem[CMD_DATA + 3]};

  ////////////////////////////////////////////////////////////////////
  // decoder and interrupt units
  assign c.code = cmd_mem[W_CODE];
  assign c.size = cmd_mem[W_SIZE];
  assign c.info = cmd_mem[W_INFO];
  assign c.fcnt = cmd_mem[W_FCNT];
  assign c.fnum = cmd_mem[W_FNUM];
  assign c.ofsh = cmd_mem[W_OFSH];
  assign c.ofsl = cmd_mem[W_OFSL];

  ncm_dec u_dec (
    .c (c)
  );

  ncm_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (c)
  );

  assign c.ev[EV_DONE]  = exec;
  assign c.ev[EV_FAULT] = exec && (fault_w != FAULT_NONE);
  assign c.clr          = (wr && sel_stat) ? pwdata[EV_W-1:0] : '0;
  assign c.mask_we      = wr && sel_mask;
  assign c.mask_val     = pwdata[EV_W-1:0];
  assign irq            = c.irq;

  ////////////////////////////////////////////////////////////////////
  // command execution
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: next_state = start ? S_EXEC : S_IDLE;
      S_EXEC: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // unknown code first, then frame shape, then phase check
  assign fault_w =
    (c.kind == CK_NONE)                      ? FAULT_CODE  :
    (!c.frame_ok || !c.size_ok)              ? FAULT_FRAME :
    (c.restricted && !init_phase)            ? FAULT_INIT  :
                                               FAULT_NONE;
  wire apply = exec && (fault_w == FAULT_NONE);

  assign dns_word[0] = dns_pri[31:16];
  assign dns_word[1] = dns_pri[15:0];
  assign dns_word[2] = dns_sec[31:16];
  assign dns_word[3] = dns_sec[15:0];

  always_comb begin
    for (int i = 0; i < RSP_WORDS; i++) begin
      next_rsp[i] = '0;
    end
    next_rsp[W_ID]    = cmd_mem[W_ID];
    next_rsp[W_INFO]  = INFO_RSP;
    next_rsp[W_CODE]  = c.code;
    next_rsp[W_SIZE]  = (c.kind == CK_DNS_RD) ? SIZE_DNS : c.size;
    next_rsp[W_FCNT]  = FRAME_ONE;
    next_rsp[W_FNUM]  = FRAME_ONE;
    next_rsp[W_OFSH]  = OFFSET_ZERO;
    next_rsp[W_OFSL]  = OFFSET_ZERO;
    next_rsp[W_FAULT] = fault_w;
    for (int i = 0; i < DATA_WORDS; i++) begin
      // read answers live settings, writes echo the request
      next_rsp[RSP_DATA + i] = (c.kind == CK_DNS_RD) ?
                               dns_word[i] :
                               cmd_mem[CMD_DATA + i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RSP_WORDS; i++) begin
        rsp_mem[i] <= '0;
      end
    end else if (exec) begin
      for (int i = 0; i < RSP_WORDS; i++) begin
        rsp_mem[i] <= next_rsp[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // network settings
  // dhcp only ever switched on here; only reset clears dhcp_cmd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dhcp_cmd <= 1'b0;
      dhcp_on  <= 1'b0;
    end else begin
      if (apply && c.kind == CK_DHCP_ON) begin
        dhcp_cmd <= 1'b1;
      end
      dhcp_on <= dhcp_cmd || cfg_file_dhcp;
    end
  end

  assign web_dhcp_checkbox  = dhcp_on;
  assign ipcfg_dhcp_visible = dhcp_on;

  // unused slots stay zero, so a read reports them as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dns_pri            <= '0;
      dns_sec            <= '0;
      dns_secondary_used <= 1'b0;
    end else if (apply && c.kind == CK_DNS_WR) begin
      dns_pri            <= cmd_data[63:32];
      dns_sec            <= cmd_data[31:0];
      dns_secondary_used <= (cmd_data[31:0] != '0);
    end
  end

  assign dns_primary   = dns_pri;
  assign dns_secondary = dns_sec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smtp_cmd      <= '0;
      smtp_override <= 1'b0;
      smtp_server   <= '0;
    end else begin
      if (apply && c.kind == CK_SMTP_WR) begin
        smtp_cmd      <= cmd_data[63:32];
        smtp_override <= 1'b1;
      end
      smtp_server <= smtp_override ? smtp_cmd : cfg_file_smtp;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_good(ncm_cmd_type k);
    exec && fault_w == FAULT_NONE && c.kind == k;
  endsequence

  property p_dhcp_apply;
    s_good(CK_DHCP_ON) |-> ##2 dhcp_on ##1 dhcp_on;
  endproperty
  a_dhcp_apply: assert property (p_dhcp_apply)
    else $error("dhcp not on after enable command");

  property p_dhcp_show;
    $rose(dhcp_on) |-> web_dhcp_checkbox && ipcfg_dhcp_visible;
  endproperty
  a_dhcp_show: assert property (p_dhcp_show)
    else $error("dhcp state not shown");

  property p_dhcp_off;
    !$past(dhcp_cmd) && !$past(cfg_file_dhcp) |-> !dhcp_on;
  endproperty
  a_dhcp_off: assert property (p_dhcp_off)
    else $error("dhcp on without cause");

  property p_fault_flag;
    exec && fault_w != FAULT_NONE |=>
      c.status[EV_FAULT] && rsp_mem[W_FAULT] == $past(fault_w);
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("fault not reported");

  property p_dns_store;
    s_good(CK_DNS_WR) |=> dns_primary == $past(cmd_data[63:32]) &&
                          dns_secondary == $past(cmd_data[31:0]);
  endproperty
  a_dns_store: assert property (p_dns_store)
    else $error("dns addresses not stored");

  property p_sec_used;
    dns_secondary_used == (dns_secondary != '0);
  endproperty
  a_sec_used: assert property (p_sec_used)
    else $error("secondary use flag wrong");

  property p_dns_read;
    exec && c.kind == CK_DNS_RD |=> rsp_mem[W_SIZE] == SIZE_DNS &&
      rsp_mem[RSP_DATA] == $past(dns_pri[31:16]) &&
      rsp_mem[RSP_DATA + 3] == $past(dns_sec[15:0]);
  endproperty
  a_dns_read: assert property (p_dns_read)
    else $error("dns read response wrong");

  property p_dns_zero;
    exec && c.kind == CK_DNS_RD && !dns_secondary_used |=>
      rsp_mem[RSP_DATA + 2] == '0 && rsp_mem[RSP_DATA + 3] == '0;
  endproperty
  a_dns_zero: assert property (p_dns_zero)
    else $error("unused dns slot not zero");

  property p_smtp_take;
    s_good(CK_SMTP_WR) |-> ##2 smtp_server == $past(cmd_data[63:32], 2);
  endproperty
  a_smtp_take: assert property (p_smtp_take)
    else $error("smtp address not adopted");

  property p_smtp_over;
    smtp_override && $past(smtp_override) |->
      smtp_server == $past(smtp_cmd);
  endproperty
  a_smtp_over: assert property (p_smtp_over)
    else $error("stored smtp used despite command");

  property p_smtp_echo;
    exec && c.kind == CK_SMTP_WR |=>
      {rsp_mem[RSP_DATA], rsp_mem[RSP_DATA + 1]} ==
      $past(cmd_data[63:32]);
  endproperty
  a_smtp_echo: assert property (p_smtp_echo)
    else $error("smtp response does not echo");

  property p_frame;
    exec && c.kind != CK_NONE && !c.frame_ok |=>
      rsp_mem[W_FAULT] == FAULT_FRAME && $stable(dhcp_cmd) &&
      $stable(dns_pri);
  endproperty
  a_frame: assert property (p_frame)
    else $error("bad frame accepted");

  property p_reject;
    exec && c.restricted && c.frame_ok && c.size_ok && !init_phase |=>
      rsp_mem[W_FAULT] == FAULT_INIT && $stable(smtp_cmd) &&
      $stable(dns_sec) && $stable(dhcp_cmd);
  endproperty
  a_reject: assert property (p_reject)
    else $error("setting applied outside init");
endmodule

// ==== testbench/ncm_host.sv ====
`timescale 1ns/100ps
module ncm_host
  import ncm_pkg::*;
(
  input  wire logic              pclk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [APB_AW-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one idle edge first, so two calls never drive psel twice in a step
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // whole message, then go with the init bit as asked
  task automatic send(input logic [15:0] code, input logic [15:0] size,
                      input logic [15:0] fcnt, input logic [63:0] d,
                      input logic init);
    logic [15:0] hdr [8];
    hdr = '{16'h00A5, INFO_CMD, code, size, fcnt, FRAME_ONE,
            OFFSET_ZERO, OFFSET_ZERO};
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, OFS_CMD + 12'(4 * i), {16'h0000, hdr[i]});
    end
    for (int i = 0; i < DATA_WORDS; i++) begin
      xfer(1'b1, OFS_CMD + 12'(4 * (CMD_DATA + i)),
           {16'h0000, d[63-16*i -: 16]});
    end
    xfer(1'b1, OFS_CTRL, {30'h0, init, 1'b1});
  endtask
endmodule

// ==== testbench/ncm_top_tb.sv ====
`timescale 1ns/100ps
module ncm_top_tb;
  import ncm_pkg::*;
  localparam logic [31:0] SMTP_FILE = 32'hC0A8_0105;
  localparam logic [63:0] DNS_A     = 64'h0A00_0001_0000_0000;
  localparam logic [63:0] DNS_B     = 64'hC0A8_0001_0808_0404;
  localparam logic [63:0] SMTP_A    = 64'hC0A8_0142_0000_0000;
  logic              pclk;
  logic              presetn;
  logic              cfg_file_dhcp;
  logic [31:0]       cfg_file_smtp;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              dhcp_on;
  logic              web_dhcp_checkbox;
  logic              ipcfg_dhcp_visible;
  logic [31:0]       dns_primary;
  logic [31:0]       dns_secondary;
  logic              dns_secondary_used;
  logic [31:0]       smtp_server;
  int                failures;
  int                n_compared;
  int                cycles;

  ncm_top ncm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cfg_file_dhcp(cfg_file_dhcp), .cfg_file_smtp(cfg_file_smtp),
    .dhcp_on(dhcp_on), .web_dhcp_checkbox(web_dhcp_checkbox),
    .ipcfg_dhcp_visible(ipcfg_dhcp_visible), .dns_primary(dns_primary),
    .dns_secondary(dns_secondary),
    .dns_secondary_used(dns_secondary_used), .smtp_server(smtp_server));

  ncm_host ncm_host_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ceiling well above the roughly 1000 cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [11:0] a,
                      input logic [31:0] e);
    ncm_host_i.xfer(1'b0, a, 32'h0);
    chk(n, e, ncm_host_i.rd_data);
  endtask

  task automatic dchk(input logic [63:0] e);
    for (int i = 0; i < DATA_WORDS; i++) begin
      rchk("rsp_data", OFS_RSP + 12'(4 * (RSP_DATA + i)),
           {16'h0, e[63-16*i -: 16]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one command: wait for the level interrupt, check header and status
  task automatic run(input logic [15:0] code, input logic [15:0] size,
                     input logic [15:0] fcnt, input logic [63:0] d,
                     input logic init, input logic [15:0] rsize,
                     input logic [15:0] fault);
    logic [15:0] ex [9];
    int          n;
    ex = '{16'h00A5, INFO_RSP, code, rsize, FRAME_ONE, FRAME_ONE,
           OFFSET_ZERO, OFFSET_ZERO, fault};
    ncm_host_i.send(code, size, fcnt, d, init);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
    for (int i = 0; i < 9; i++) begin
      rchk("rsp_hdr", OFS_RSP + 12'(4 * i), {16'h0, ex[i]});
    end
    rchk("status", OFS_STAT, {30'h0, fault != FAULT_NONE, 1'b1});
    ncm_host_i.xfer(1'b1, OFS_STAT, 32'h3);
    rchk("stat_clr", OFS_STAT, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask

  initial begin
    failures      = 0;
    n_compared    = 0;
    cycles        = 0;
    presetn       = 1'b0;
    cfg_file_dhcp = 1'b0;
    cfg_file_smtp = SMTP_FILE;
    repeat (12) @(posedge pclk);
    chk("dhcp_rst", 32'h0, {31'h0, dhcp_on});
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("dhcp_idle", 32'h0, {31'h0, dhcp_on});
    chk("smtp_file", SMTP_FILE, smtp_server);
    rchk("ctrl", OFS_CTRL, 32'h2);
    rchk("mask", OFS_MASK, 32'h0);
    rchk("state", OFS_STATE, 32'h0);
    ncm_host_i.xfer(1'b1, OFS_MASK, 32'h3);
    run(CODE_DHCP_ON, SIZE_NONE, FRAME_ONE, 64'h0, 1'b1, SIZE_NONE,
        FAULT_NONE);
    @(negedge pclk);
    chk("dhcp_on", 32'h1, {31'h0, dhcp_on});
    chk("web", 32'h1, {31'h0, web_dhcp_checkbox});
    chk("ipcfg", 32'h1, {31'h0, ipcfg_dhcp_visible});
    rchk("state_dhcp", OFS_STATE, 32'h1);
    run(CODE_DHCP_ON, SIZE_NONE, 16'h0002, 64'h0, 1'b1, SIZE_NONE,
        FAULT_FRAME);
    run(16'h0077, SIZE_NONE, FRAME_ONE, 64'h0, 1'b1, SIZE_NONE, FAULT_CODE);
    run(CODE_DNS_WR, SIZE_SMTP, FRAME_ONE, DNS_B, 1'b1, SIZE_SMTP,
        FAULT_FRAME);
    run(CODE_DNS_WR, SIZE_DNS, FRAME_ONE, DNS_A, 1'b1, SIZE_DNS,
        FAULT_NONE);
    dchk(DNS_A);
    chk("dns_pri", DNS_A[63:32], dns_primary);
    chk("dns_used", 32'h0, {31'h0, dns_secondary_used});
    run(CODE_DNS_RD, SIZE_NONE, FRAME_ONE, 64'h0, 1'b1, SIZE_DNS,
        FAULT_NONE);
    dchk(DNS_A);
    run(CODE_DNS_WR, SIZE_DNS, FRAME_ONE, DNS_B, 1'b1, SIZE_DNS,
        FAULT_NONE);
    chk("dns_sec", DNS_B[31:0], dns_secondary);
    chk("dns_used2", 32'h1, {31'h0, dns_secondary_used});
    run(CODE_SMTP_WR, SIZE_SMTP, FRAME_ONE, SMTP_A, 1'b1, SIZE_SMTP,
        FAULT_NONE);
    dchk(SMTP_A);
    chk("smtp", SMTP_A[63:32], smtp_server);
    // leave init; setting commands must now bounce, reads still work
    ncm_host_i.xfer(1'b1, OFS_CTRL, 32'h0);
    run(CODE_SMTP_WR, SIZE_SMTP, FRAME_ONE, DNS_B, 1'b0, SIZE_SMTP,
        FAULT_INIT);
    run(CODE_DNS_WR, SIZE_DNS, FRAME_ONE, DNS_A, 1'b0, SIZE_DNS,
        FAULT_INIT);
    chk("smtp_kept", SMTP_A[63:32], smtp_server);
    run(CODE_DNS_RD, SIZE_NONE, FRAME_ONE, 64'h0, 1'b0, SIZE_DNS,
        FAULT_NONE);
    dchk(DNS_B);
    // bus refusals leave the response untouched
    ncm_host_i.xfer(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, ncm_host_i.rd_err});
    chk("unmapped_rd", 32'h0, ncm_host_i.rd_data);
    ncm_host_i.xfer(1'b1, OFS_RSP, 32'h1234);
    chk("rsp_wr_err", 32'h1, {31'h0, ncm_host_i.rd_err});
    rchk("rsp_id", OFS_RSP, 32'h00A5);
    // masked event sets status but keeps irq low until unmasked
    ncm_host_i.xfer(1'b1, OFS_MASK, 32'h0);
    ncm_host_i.send(CODE_DNS_RD, SIZE_NONE, FRAME_ONE, 64'h0, 1'b0);
    repeat (6) @(negedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("stat_masked", OFS_STAT, 32'h1);
    ncm_host_i.xfer(1'b1, OFS_MASK, 32'h1);
    @(negedge pclk);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    ncm_host_i.xfer(1'b1, OFS_STAT, 32'h1);
    @(negedge pclk);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    close_out();
  end
endmodule
